// >>> verilog/sia_consts.vh
// Register map, field layout and reset values of the interrupt aggregator
`ifndef SIA_CONSTS_VH
`define SIA_CONSTS_VH

`define SIA_ADDR_CFG 32'h44050600
`define SIA_ADDR_STAT 32'h44050604

`define SIA_CFG_RESET 32'h00000000
`define SIA_STAT_RESET 32'h00000000
`define SIA_CFG_WMASK 32'hCF0F0FFB
`define SIA_LATCH_MASK 32'h0F0F0F0A

`define SIA_BIT_PATTERN 31
`define SIA_BIT_SCHED 30
`define SIA_LSB_EEE 24
`define SIA_LSB_TSTAMP 16
`define SIA_LSB_LINK 8
`define SIA_BIT_HUB 7
`define SIA_BIT_REDUND 6
`define SIA_BIT_RING 5
`define SIA_BIT_TEST 4
`define SIA_BIT_NEWSRC 3
`define SIA_BIT_MGMT 1
`define SIA_BIT_GLOBAL 0
`define SIA_BIT_PEND 0

`endif

// >>> verilog/sia_top.v
// Switch interrupt aggregator with APB register access
//
// Added by the designer: the APB interface to the registers.
`include "sia_consts.vh"

module sia_top (
    input wire clock,
    input wire rstn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [3:0] energy_state,
    input wire [3:0] tx_stamp_stored,
    input wire [3:0] phy_link_status,
    input wire new_source_address_event,
    input wire mgmt_transaction_done,
    input wire pattern_interrupt_in,
    input wire scheduler_interrupt_in,
    input wire hub_interrupt_in,
    input wire redundancy_interrupt_in,
    input wire ring_interrupt_in,
    output reg host_interrupt_out,
    output reg pattern_interrupt_out,
    output reg scheduler_interrupt_out,
    output reg hub_interrupt_out,
    output reg redundancy_interrupt_out,
    output reg ring_interrupt_out
);

    function addr_hit;
        input [31:0] addr;
        input [31:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    function [31:0] read_select;
        input sel_cfg;
        input sel_stat;
        input [31:0] cfg_word;
        input [31:0] stat_word;
        begin
            read_select = 32'h00000000;
            if (sel_cfg) begin
                read_select = cfg_word;
            end else if (sel_stat) begin
                read_select = stat_word;
            end
        end
    endfunction

    reg [31:0] cfg_q;
    reg [31:0] cfg_d;
    reg [31:0] latch_q;
    wire [31:0] latch_d;
    reg [3:0] energy_prev_q;
    reg [3:0] link_meta_q;
    reg [3:0] link_sync_q;
    reg [3:0] link_prev_q;
    reg [31:0] events;
    reg [31:0] status_view;
    reg [31:0] rdata_d;
    reg pending;
    wire access;
    wire commit;
    wire hit_cfg;
    wire hit_stat;

    assign hit_cfg = addr_hit(paddr, `SIA_ADDR_CFG);
    assign hit_stat = addr_hit(paddr, `SIA_ADDR_STAT);
    // First access cycle raises pready; the transfer completes one edge later
    assign access = psel & penable & ~pready;
    assign commit = psel & penable & pready;

    // Write strobes and error decode
    wire cfg_write;
    wire stat_write;
    wire unmapped;
    wire read_access;
    assign cfg_write = commit & pwrite & hit_cfg;
    assign stat_write = commit & pwrite & hit_stat;
    assign unmapped = ~(hit_cfg | hit_stat);
    assign read_access = access & ~pwrite;

    // Link level from the pins passes two flip-flops
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_link
            always @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    link_meta_q[gi] <= 1'b0;
                    link_sync_q[gi] <= 1'b0;
                    link_prev_q[gi] <= 1'b0;
                end else begin
                    link_meta_q[gi] <= phy_link_status[gi];
                    link_sync_q[gi] <= link_meta_q[gi];
                    link_prev_q[gi] <= link_sync_q[gi];
                end
            end
        end
    endgenerate

    // Energy state history on the same clock
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_energy
            always @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    energy_prev_q[gi] <= 1'b0;
                end else begin
                    energy_prev_q[gi] <= energy_state[gi];
                end
            end
        end
    endgenerate

    // Per-port change and capture events
    wire [3:0] energy_change;
    wire [3:0] stamp_event;
    wire [3:0] link_change;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_port_evt
            assign energy_change[gi] = energy_state[gi] ^ energy_prev_q[gi];
            assign stamp_event[gi] = tx_stamp_stored[gi];
            assign link_change[gi] = link_sync_q[gi] ^ link_prev_q[gi];
        end
    endgenerate


    // Event vector aligned to the status bit layout
    always @* begin
        events = 32'h00000000;
        events[`SIA_LSB_EEE +: 4] = energy_change;
        events[`SIA_LSB_TSTAMP +: 4] = stamp_event;
        events[`SIA_LSB_LINK +: 4] = link_change;
        events[`SIA_BIT_NEWSRC] = new_source_address_event;
        events[`SIA_BIT_MGMT] = mgmt_transaction_done;
    end

    // Latches: write one clears, a new event wins
    wire [31:0] clear_mask;
    genvar bi;
    assign clear_mask = stat_write ? (pwdata & `SIA_LATCH_MASK) : 32'h00000000;
    generate
        for (bi = 0; bi < 32; bi = bi + 1) begin : g_latch
            if (((`SIA_LATCH_MASK >> bi) & 32'h00000001) != 32'h00000000) begin : g_used
                assign latch_d[bi] = (latch_q[bi] & ~clear_mask[bi]) | events[bi];
            end else begin : g_unused
                assign latch_d[bi] = 1'b0;
            end
        end
    endgenerate

    // Latches that are both set and enabled
    wire [31:0] latch_armed;
    assign latch_armed = latch_q & cfg_q & `SIA_LATCH_MASK;

    always @* begin
        cfg_d = cfg_q;
        if (cfg_write) begin
            cfg_d = pwdata & `SIA_CFG_WMASK;
        end
    end

    // Live sources gated by their forward enables
    wire [4:0] live_in;
    wire [4:0] live_en;
    wire [4:0] live_fwd;
    assign live_in[4] = pattern_interrupt_in;
    assign live_in[3] = scheduler_interrupt_in;
    assign live_in[2] = hub_interrupt_in;
    assign live_in[1] = redundancy_interrupt_in;
    assign live_in[0] = ring_interrupt_in;
    assign live_en[4] = cfg_q[`SIA_BIT_PATTERN];
    assign live_en[3] = cfg_q[`SIA_BIT_SCHED];
    assign live_en[2] = cfg_q[`SIA_BIT_HUB];
    assign live_en[1] = cfg_q[`SIA_BIT_REDUND];
    assign live_en[0] = cfg_q[`SIA_BIT_RING];
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_fwd
            assign live_fwd[gi] = live_in[gi] & live_en[gi];
        end
    endgenerate

    // Summary of every enabled and pending source
    always @* begin
        pending = |latch_armed;
        if (cfg_q[`SIA_BIT_TEST]) begin
            pending = 1'b1;
        end
        if (live_fwd[4]) begin
            pending = 1'b1;
        end
        if (live_fwd[3]) begin
            pending = 1'b1;
        end
        if (live_fwd[2]) begin
            pending = 1'b1;
        end
        if (live_fwd[1]) begin
            pending = 1'b1;
        end
        if (live_fwd[0]) begin
            pending = 1'b1;
        end
    end

    // Next level of the host line
    wire host_next;
    assign host_next = cfg_q[`SIA_BIT_GLOBAL] & pending;

    // Status read view; live bits are copies and cannot be written
    always @* begin
        status_view = latch_q & `SIA_LATCH_MASK;
        status_view[`SIA_BIT_PATTERN] = pattern_interrupt_in;
        status_view[`SIA_BIT_SCHED] = scheduler_interrupt_in;
        status_view[`SIA_BIT_HUB] = hub_interrupt_in;
        status_view[`SIA_BIT_REDUND] = redundancy_interrupt_in;
        status_view[`SIA_BIT_RING] = ring_interrupt_in;
        status_view[`SIA_BIT_TEST] = cfg_q[`SIA_BIT_TEST];
        status_view[`SIA_BIT_PEND] = pending;
    end

    always @* begin
        rdata_d = read_select(hit_cfg, hit_stat, cfg_q, status_view);
    end

    // Enable register
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cfg_q <= `SIA_CFG_RESET;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // Event latches
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            latch_q <= `SIA_STAT_RESET;
        end else begin
            latch_q <= latch_d;
        end
    end

    // One wait state, then the answer
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
        end else begin
            pready <= access;
        end
    end

    // Unmapped address flags an error with pready
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pslverr <= 1'b0;
        end else begin
            if (access) begin
                pslverr <= unmapped;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // Read data stands only with pready
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h00000000;
        end else begin
            if (read_access) begin
                prdata <= rdata_d;
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // Host line
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            host_interrupt_out <= 1'b0;
        end else begin
            host_interrupt_out <= host_next;
        end
    end

    // Dedicated pattern output
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pattern_interrupt_out <= 1'b0;
        end else begin
            pattern_interrupt_out <= pattern_interrupt_in;
        end
    end

    // Dedicated scheduler output
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            scheduler_interrupt_out <= 1'b0;
        end else begin
            scheduler_interrupt_out <= scheduler_interrupt_in;
        end
    end

    // Dedicated hub output
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            hub_interrupt_out <= 1'b0;
        end else begin
            hub_interrupt_out <= hub_interrupt_in;
        end
    end

    // Dedicated redundancy output
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            redundancy_interrupt_out <= 1'b0;
        end else begin
            redundancy_interrupt_out <= redundancy_interrupt_in;
        end
    end

    // Dedicated ring output
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ring_interrupt_out <= 1'b0;
        end else begin
            ring_interrupt_out <= ring_interrupt_in;
        end
    end

endmodule

// >>> dv/sia_assertions.sv
// Port checks of the interrupt aggregator
`include "sia_consts.vh"
module sia_assertions (
    input clock, rstn, psel, penable, pwrite, pready, pslverr, host_interrupt_out,
    input [31:0] paddr, pwdata, prdata,
    input mgmt_transaction_done, pattern_interrupt_in, scheduler_interrupt_in,
    input hub_interrupt_in, redundancy_interrupt_in, ring_interrupt_in,
    input pattern_interrupt_out, scheduler_interrupt_out, hub_interrupt_out,
    input redundancy_interrupt_out, ring_interrupt_out
);
    logic [31:0] cfg_q;
    wire [31:0] live = {pattern_interrupt_in, scheduler_interrupt_in, 22'h0,
        hub_interrupt_in, redundancy_interrupt_in, ring_interrupt_in, 5'h0};
    wire [4:0] outs = {pattern_interrupt_out, scheduler_interrupt_out,
        hub_interrupt_out, redundancy_interrupt_out, ring_interrupt_out};
    // Shadow of the enable register
    always @(posedge clock or negedge rstn)
        if (!rstn) cfg_q <= 32'h0;
        else if (psel && penable && pready && pwrite && paddr == `SIA_ADDR_CFG)
            cfg_q <= pwdata & `SIA_CFG_WMASK;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    a_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("ready late");
    a_err_decode: assert property (pready |->
        pslverr == (paddr != `SIA_ADDR_CFG && paddr != `SIA_ADDR_STAT)) else $error("bad err");
    a_rdata_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
        else $error("stray data");
    a_resv_zero: assert property (pready |-> (prdata & ~`SIA_CFG_WMASK) == 32'h0)
        else $error("reserved set");
    a_out_copy: assert property (1'b1 |=> outs == $past({live[31:30], live[7:5]}))
        else $error("copy wrong");
    a_host_global: assert property (host_interrupt_out |-> $past(cfg_q[0]))
        else $error("host ungated");
    a_test_host: assert property (cfg_q[4] && cfg_q[0] |=> host_interrupt_out)
        else $error("test lost");
    a_mgmt_host: assert property (
        mgmt_transaction_done && cfg_q[1] && cfg_q[0] |-> ##2 host_interrupt_out)
        else $error("mgmt lost");
    a_fwd_host: assert property (
        cfg_q[0] && |(cfg_q & live) |-> ##[1:2] host_interrupt_out)
        else $error("fwd lost");
    c_mgmt: cover property (mgmt_transaction_done && cfg_q[1]);
    c_err: cover property (pslverr);
    c_host: cover property ($rose(host_interrupt_out));
endmodule
bind sia_top sia_assertions u_chk (.*);

// >>> dv/sia_partner.sv
// Event and live interrupt sources
module sia_partner (
    input clock,
    input [31:0] kick,
    output logic [3:0] energy_state, tx_stamp_stored, phy_link_status,
    output logic new_source_address_event, mgmt_transaction_done,
    output wire pattern_interrupt_in, scheduler_interrupt_in, hub_interrupt_in,
    output wire redundancy_interrupt_in, ring_interrupt_in
);
    logic [4:0] live_q;
    assign {pattern_interrupt_in, scheduler_interrupt_in, hub_interrupt_in,
        redundancy_interrupt_in, ring_interrupt_in} = live_q;
    initial {energy_state, tx_stamp_stored, phy_link_status, new_source_address_event,
        mgmt_transaction_done, live_q} = 19'h0;
    always @(posedge clock) begin
        energy_state <= energy_state ^ kick[27:24];
        tx_stamp_stored <= kick[19:16];
        phy_link_status <= phy_link_status ^ kick[11:8];
        new_source_address_event <= kick[3];
        mgmt_transaction_done <= kick[1];
        live_q <= live_q ^ {kick[31:30], kick[7:5]};
    end
endmodule

// >>> dv/sia_bench.sv
// Random tests of the interrupt aggregator
`include "sia_consts.vh"
module sia_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, kick = 32'h0, seed = 32'h95183EAC;
    logic [31:0] rd, lat, vl, c, w, e;
    wire [31:0] prdata;
    wire [3:0] energy_state, tx_stamp_stored, phy_link_status;
    wire pready, pslverr, host_interrupt_out, new_source_address_event;
    wire mgmt_transaction_done, pattern_interrupt_in, scheduler_interrupt_in;
    wire hub_interrupt_in, redundancy_interrupt_in, ring_interrupt_in;
    wire pattern_interrupt_out, scheduler_interrupt_out, hub_interrupt_out;
    wire redundancy_interrupt_out, ring_interrupt_out;
    int n_fail = 0, num_checks = 0;
    sia_top dut (.*);
    sia_partner model (.*);
    initial forever #50 clock = ~clock;
    function automatic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic [31:0] stat(input [31:0] l, v, k);
        logic [31:0] s;
        s = l | v | (k & 32'h10);
        s[0] = |(l & k) | k[4] | |(k & v);
        return s;
    endfunction
    task automatic chk(input [31:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic wr, input [31:0] a, d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic summarize();
        if (n_fail == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #3000000;
        n_fail++;
        summarize();
    end
    initial begin
        lat = 32'h0;
        vl = 32'h0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        xfer(1'b0, `SIA_ADDR_CFG, 32'h0);
        chk(rd, `SIA_CFG_RESET);
        xfer(1'b0, `SIA_ADDR_STAT, 32'h0);
        chk(rd, `SIA_STAT_RESET);
        xfer(1'b0, `SIA_ADDR_STAT + 32'h4, 32'h0);
        chk(rd | {err, 31'h0}, 32'h80000000);
        repeat (40) begin
            c = xs() & `SIA_CFG_WMASK;
            xfer(1'b1, `SIA_ADDR_CFG, c);
            xfer(1'b0, `SIA_ADDR_CFG, 32'h0);
            chk(rd, c);
            w = xs() & 32'hCF0F0FEA;
            @(posedge clock);
            kick <= w;
            @(posedge clock);
            kick <= 32'h0;
            lat = lat | (w & `SIA_LATCH_MASK);
            vl = vl ^ (w & 32'hC00000E0);
            repeat (5) @(posedge clock);
            xfer(1'b0, `SIA_ADDR_STAT, 32'h0);
            e = stat(lat, vl, c);
            chk(rd, e);
            chk({31'h0, host_interrupt_out}, {31'h0, c[0] & e[0]});
            chk({27'h0, pattern_interrupt_out, scheduler_interrupt_out, hub_interrupt_out,
                redundancy_interrupt_out, ring_interrupt_out}, {27'h0, vl[31:30], vl[7:5]});
            w = xs() & `SIA_CFG_WMASK;
            xfer(1'b1, `SIA_ADDR_STAT, w);
            lat = lat & ~w;
        end
        lat = 32'h0000000A;
        fork
            xfer(1'b1, `SIA_ADDR_STAT, `SIA_LATCH_MASK);
            begin
                repeat (2) @(posedge clock);
                kick <= 32'h0000000A;
                @(posedge clock);
                kick <= 32'h0;
            end
        join
        repeat (2) @(posedge clock);
        xfer(1'b0, `SIA_ADDR_STAT, 32'h0);
        chk(rd, stat(lat, vl, c));
        summarize();
    end
endmodule
